//--- logic/dps_map.vh
// Register offsets, field positions, reset values and widths for the debug pin sharing block.
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

// Wishbone byte offsets, one aligned 32-bit word per register.
`define DPS_ADR_FUNC        8'h00
`define DPS_ADR_IE          8'h04
`define DPS_ADR_OE          8'h08
`define DPS_ADR_OD          8'h0c
`define DPS_ADR_PUP         8'h10
`define DPS_ADR_PDN         8'h14
`define DPS_ADR_GP_OUT      8'h18
`define DPS_ADR_GP_IN       8'h1c
`define DPS_ADR_DBG_CFG     8'h20
`define DPS_ADR_STANDBY     8'h24
`define DPS_ADR_STATUS      8'h28
`define DPS_ADR_W           8

// Pin vector positions: bit 0 is port B pin 3 up to bit 3 for port B pin 6.
`define DPS_PIN3            0
`define DPS_PIN4            1
`define DPS_PIN5            2
`define DPS_PIN6            3
`define DPS_NPINS           4

// Reset values of the per-pin port control registers.
`define DPS_RST_FUNC        4'hf
`define DPS_RST_IE          4'hb
`define DPS_RST_OE          4'h5
`define DPS_RST_OD          4'h0
`define DPS_RST_PUP         4'h9
`define DPS_RST_PDN         4'h2
`define DPS_RST_GP_OUT      4'h0

// Debug configuration register fields.
`define DPS_CFG_SWD         0
`define DPS_CFG_TRACE       1
`define DPS_CFG_TMR_LSB     8
`define DPS_RST_CFG         1'b0

// Standby control register field.
`define DPS_STBY_DRIVE      0
`define DPS_RST_DRIVE       1'b0

// Status register fields.
`define DPS_ST_HALT         0
`define DPS_ST_STOP         1
`define DPS_ST_LP_FULL      2
`define DPS_ST_LINK_CLK     3
`define DPS_ST_OWN_LSB      4

// Number of 16-bit timer/counters with a halt-stop setting.
`define DPS_NUM_TIMERS      4

`endif

//--- logic/dps_pin_sync.v
// Three-flop pin synchroniser with agreement filter for inputs from outside the clock domain.
`timescale 1ns/1ps
module dps_pin_sync #(
   parameter WIDTH = 4
) (
   input  wire             clk_in,
   input  wire             rst_n_in,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;

   // Stage one feeds only stage two; the filter looks at stages two and three and its own previous output.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         stage1   <= {WIDTH{1'b0}};
         stage2   <= {WIDTH{1'b0}};
         stage3   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1   <= async_in;
         stage2   <= stage1;
         stage3   <= stage2;
         sync_out <= (stage2 & stage3) | (sync_out & (stage2 | stage3));
      end
   end
endmodule

//--- logic/dps_debug_pins.v
// Debug pin sharing: port B pins 3 to 6 between the debug link and general-purpose use, plus halt gating.
//
// Behaviour
// - Out of reset, port B pins 3, 4, 5 and 6 carry debug functions.
// - Pin 3 is TMS input or bidirectional SWDIO; pin 4 is TCK or SWCLK.
// - Pin 5 is TDO, or the trace viewer output when trace is enabled.
// - Pin 6 is only the JTAG TDI input, unused by serial wire debug.
// - Reset port settings: function 1, no open drain, documented input/output/pull values.
// - Debug pins 3 and 5 keep driving in STOP regardless of standby drive enable.
// - Pin 4 in debug function keeps low-power modes from taking full effect.
// - JTAG uses four pins, SWD two, SWD with trace three, disabled none.
// - Debug pins not needed by the chosen usage work as ordinary port pins.
// - A debug break puts the core into HALT.
// - The watchdog stops counting automatically while the core is halted.
// - Each 16-bit timer chooses whether it keeps counting or stops in HALT.
// - All other peripherals keep running while the core is halted.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "dps_map.vh"
module dps_debug_pins #(
   parameter NUM_TIMERS = `DPS_NUM_TIMERS
) (
   input  wire                  clk_in,
   input  wire                  rst_n_in,
   // Classic Wishbone slave.
   input  wire                  wb_cyc_in,
   input  wire                  wb_stb_in,
   input  wire                  wb_we_in,
   input  wire [7:0]            wb_adr_in,
   input  wire [3:0]            wb_sel_in,
   input  wire [31:0]           wb_dat_in,
   output reg  [31:0]           wb_dat_out,
   output reg                   wb_ack_out,
   // Port B pins 3..6 as input, output and output enable, plus pad controls.
   input  wire [3:0]            pin_in,
   output reg  [3:0]            pin_out,
   output reg  [3:0]            pin_oe_out,
   output reg  [3:0]            pin_ie_out,
   output reg  [3:0]            pin_pullup_out,
   output reg  [3:0]            pin_pulldown_out,
   // Towards the internal debug port.
   output reg                   dbg_tms_swdio_out,
   output reg                   dbg_tdi_out,
   output reg                   dbg_clk_level_out,
   output reg                   dbg_clk_rise_out,
   output reg                   dbg_clk_fall_out,
   output reg                   dbg_swd_mode_out,
   input  wire                  dbg_swdio_data_in,
   input  wire                  dbg_swdio_oe_in,
   input  wire                  dbg_tdo_in,
   input  wire                  dbg_trace_in,
   input  wire                  dbg_break_in,
   input  wire                  dbg_resume_in,
   // Low-power and halt side effects.
   input  wire                  stop_req_in,
   output reg                   low_power_full_out,
   output reg                   core_halt_out,
   output reg                   watchdog_count_en_out,
   output reg  [NUM_TIMERS-1:0] timer_count_en_out
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   reg  [3:0]            port_b_function_select;
   reg  [3:0]            port_b_input_enable;
   reg  [3:0]            port_b_output_enable;
   reg  [3:0]            port_b_open_drain;
   reg  [3:0]            port_b_pullup;
   reg  [3:0]            port_b_pulldown;
   reg  [3:0]            gp_data;
   reg                   swd_mode;
   reg                   trace_en;
   reg  [NUM_TIMERS-1:0] timer_halt_stop;
   reg                   standby_drive_enable;
   reg                   halted;
   reg                   clk_prev;
   wire [3:0]            pin_sync;
   reg  [3:0]            needed;
   wire [3:0]            owned;
   wire                  req;
   wire                  wr_en;
   reg  [31:0]           next_rdata;
   reg  [31:0]           wmask;

   dps_pin_sync #(
      .WIDTH    (`DPS_NPINS)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Which pins the chosen protocol actually uses.
   always @* begin
      needed[`DPS_PIN3] = 1'b1;
      needed[`DPS_PIN4] = 1'b1;
      needed[`DPS_PIN5] = !swd_mode || trace_en;
      needed[`DPS_PIN6] = !swd_mode;
   end

   // A pin belongs to debug only while selected and needed; otherwise it is a port pin.
   assign owned = port_b_function_select & needed;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Wishbone: ack one cycle after the request; writes land on the edge where ack is high.
   assign req   = wb_cyc_in && wb_stb_in;
   assign wr_en = req && wb_we_in && wb_ack_out;

   always @* begin
      wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
      next_rdata = 32'h0000_0000;
      if (wb_adr_in == `DPS_ADR_FUNC) begin
         next_rdata[3:0] = port_b_function_select;
      end else if (wb_adr_in == `DPS_ADR_IE) begin
         next_rdata[3:0] = port_b_input_enable;
      end else if (wb_adr_in == `DPS_ADR_OE) begin
         next_rdata[3:0] = port_b_output_enable;
      end else if (wb_adr_in == `DPS_ADR_OD) begin
         next_rdata[3:0] = port_b_open_drain;
      end else if (wb_adr_in == `DPS_ADR_PUP) begin
         next_rdata[3:0] = port_b_pullup;
      end else if (wb_adr_in == `DPS_ADR_PDN) begin
         next_rdata[3:0] = port_b_pulldown;
      end else if (wb_adr_in == `DPS_ADR_GP_OUT) begin
         next_rdata[3:0] = gp_data;
      end else if (wb_adr_in == `DPS_ADR_GP_IN) begin
         next_rdata[3:0] = pin_sync & port_b_input_enable;
      end else if (wb_adr_in == `DPS_ADR_DBG_CFG) begin
         next_rdata[`DPS_CFG_SWD]   = swd_mode;
         next_rdata[`DPS_CFG_TRACE] = trace_en;
         next_rdata[`DPS_CFG_TMR_LSB +: NUM_TIMERS] = timer_halt_stop;
      end else if (wb_adr_in == `DPS_ADR_STANDBY) begin
         next_rdata[`DPS_STBY_DRIVE] = standby_drive_enable;
      end else if (wb_adr_in == `DPS_ADR_STATUS) begin
         next_rdata[`DPS_ST_HALT]     = halted;
         next_rdata[`DPS_ST_STOP]     = stop_req_in;
         next_rdata[`DPS_ST_LP_FULL]  = low_power_full_out;
         next_rdata[`DPS_ST_LINK_CLK] = pin_sync[`DPS_PIN4];
         next_rdata[`DPS_ST_OWN_LSB +: 4] = owned;
      end
   end

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= req && !wb_ack_out;
         if (req && !wb_ack_out) begin
            wb_dat_out <= next_rdata;
         end
      end
   end

   // Software may rewrite the function select at any time; the hardware cannot tell whether a
   // probe is attached, so keeping debug pins during a session is left to the program.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         port_b_function_select <= `DPS_RST_FUNC;
         port_b_input_enable    <= `DPS_RST_IE;
         port_b_output_enable   <= `DPS_RST_OE;
         port_b_open_drain      <= `DPS_RST_OD;
         port_b_pullup          <= `DPS_RST_PUP;
         port_b_pulldown        <= `DPS_RST_PDN;
         gp_data                <= `DPS_RST_GP_OUT;
         swd_mode               <= `DPS_RST_CFG;
         trace_en               <= `DPS_RST_CFG;
         timer_halt_stop        <= {NUM_TIMERS{1'b0}};
         standby_drive_enable   <= `DPS_RST_DRIVE;
      end else if (wr_en) begin
         if (wb_adr_in == `DPS_ADR_FUNC) begin
            port_b_function_select <= (port_b_function_select & ~wmask[3:0]) | (wb_dat_in[3:0] & wmask[3:0]);
         end else if (wb_adr_in == `DPS_ADR_IE) begin
            port_b_input_enable <= (port_b_input_enable & ~wmask[3:0]) | (wb_dat_in[3:0] & wmask[3:0]);
         end else if (wb_adr_in == `DPS_ADR_OE) begin
            port_b_output_enable <= (port_b_output_enable & ~wmask[3:0]) | (wb_dat_in[3:0] & wmask[3:0]);
         end else if (wb_adr_in == `DPS_ADR_OD) begin
            port_b_open_drain <= (port_b_open_drain & ~wmask[3:0]) | (wb_dat_in[3:0] & wmask[3:0]);
         end else if (wb_adr_in == `DPS_ADR_PUP) begin
            port_b_pullup <= (port_b_pullup & ~wmask[3:0]) | (wb_dat_in[3:0] & wmask[3:0]);
         end else if (wb_adr_in == `DPS_ADR_PDN) begin
            port_b_pulldown <= (port_b_pulldown & ~wmask[3:0]) | (wb_dat_in[3:0] & wmask[3:0]);
         end else if (wb_adr_in == `DPS_ADR_GP_OUT) begin
            gp_data <= (gp_data & ~wmask[3:0]) | (wb_dat_in[3:0] & wmask[3:0]);
         end else if (wb_adr_in == `DPS_ADR_DBG_CFG) begin
            if (wb_sel_in[0]) begin
               swd_mode <= wb_dat_in[`DPS_CFG_SWD];
               trace_en <= wb_dat_in[`DPS_CFG_TRACE];
            end
            if (wb_sel_in[1]) begin
               timer_halt_stop <= wb_dat_in[`DPS_CFG_TMR_LSB +: NUM_TIMERS];
            end
         end else if (wb_adr_in == `DPS_ADR_STANDBY) begin
            if (wb_sel_in[0]) begin
               standby_drive_enable <= wb_dat_in[`DPS_STBY_DRIVE];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pad multiplexer, registered so every pad control comes straight from a flip-flop.
   genvar i;
   generate
      for (i = 0; i < `DPS_NPINS; i = i + 1) begin : g_pad
         always @(posedge clk_in) begin
            if (!rst_n_in) begin
               pin_out[i]          <= 1'b0;
               pin_oe_out[i]       <= 1'b0;
               pin_ie_out[i]       <= 1'b0;
               pin_pullup_out[i]   <= 1'b0;
               pin_pulldown_out[i] <= 1'b0;
            end else begin
               pin_ie_out[i]       <= port_b_input_enable[i];
               pin_pullup_out[i]   <= port_b_pullup[i];
               pin_pulldown_out[i] <= port_b_pulldown[i];
               if (owned[i]) begin
                  // Debug pins ignore the standby drive bit, so STOP never cuts the probe off.
                  if (i == `DPS_PIN3) begin
                     pin_out[i]    <= dbg_swdio_data_in;
                     pin_oe_out[i] <= port_b_output_enable[i] && swd_mode && dbg_swdio_oe_in;
                  end else if (i == `DPS_PIN5) begin
                     pin_out[i]    <= trace_en ? dbg_trace_in : dbg_tdo_in;
                     pin_oe_out[i] <= port_b_output_enable[i];
                  end else begin
                     pin_out[i]    <= 1'b0;
                     pin_oe_out[i] <= 1'b0;
                  end
               end else begin
                  // Open drain only ever pulls low; a high level is left to the pull-up.
                  pin_out[i]    <= port_b_open_drain[i] ? 1'b0 : gp_data[i];
                  pin_oe_out[i] <= port_b_output_enable[i]
                                   && (!port_b_open_drain[i] || !gp_data[i])
                                   && (!stop_req_in || standby_drive_enable);
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Link side: the probe clock is sampled by clk_in, so it must stay well below half its rate.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         clk_prev          <= 1'b0;
         dbg_clk_level_out <= 1'b0;
         dbg_clk_rise_out  <= 1'b0;
         dbg_clk_fall_out  <= 1'b0;
         dbg_tms_swdio_out <= 1'b0;
         dbg_tdi_out       <= 1'b0;
         dbg_swd_mode_out  <= 1'b0;
      end else begin
         clk_prev          <= pin_sync[`DPS_PIN4];
         dbg_clk_level_out <= owned[`DPS_PIN4] && pin_sync[`DPS_PIN4];
         dbg_clk_rise_out  <= owned[`DPS_PIN4] && pin_sync[`DPS_PIN4] && !clk_prev;
         dbg_clk_fall_out  <= owned[`DPS_PIN4] && !pin_sync[`DPS_PIN4] && clk_prev;
         dbg_tms_swdio_out <= owned[`DPS_PIN3] && pin_sync[`DPS_PIN3];
         dbg_tdi_out       <= owned[`DPS_PIN6] && pin_sync[`DPS_PIN6];
         dbg_swd_mode_out  <= swd_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Halt state and its effect on the watchdog and timers; a break beats a resume.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         halted <= 1'b0;
      end else if (dbg_break_in) begin
         halted <= 1'b1;
      end else if (dbg_resume_in) begin
         halted <= 1'b0;
      end
   end

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         core_halt_out         <= 1'b0;
         watchdog_count_en_out <= 1'b1;
         timer_count_en_out    <= {NUM_TIMERS{1'b1}};
         low_power_full_out    <= 1'b0;
      end else begin
         core_halt_out         <= halted;
         watchdog_count_en_out <= !halted;
         timer_count_en_out    <= ~({NUM_TIMERS{halted}} & timer_halt_stop);
         // Only the watchdog and timers see the halt; no other enable is gated here.
         low_power_full_out    <= stop_req_in && !owned[`DPS_PIN4];
      end
   end
endmodule

//--- bench/dps_probe.sv
// Behavioural debug probe that clocks frames onto the shared debug pins.
`timescale 1ns/1ps
module dps_probe (
   output reg [3:0] drv_out,
   output reg [3:0] oe_out
);
   initial begin
      drv_out = 4'h0;
      oe_out  = 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // The probe clock stands low between frames, so the block sees no stray edges.
   // Data changes while the clock is low and is held through the rising edge.
   task frame(input [7:0] tms, input [7:0] tdi, input swd);
      integer i;
      begin
         #2;
         oe_out = swd ? 4'b0011 : 4'b1011;
         for (i = 7; i >= 0; i = i - 1) begin
            drv_out[0] = tms[i];
            drv_out[3] = tdi[i];
            #62.5 drv_out[1] = 1'b1;
            #62.5 drv_out[1] = 1'b0;
         end
      end
   endtask
endmodule

//--- bench/dps_debug_pins_properties.sv
// Concurrent checks on the ports of the debug pin sharing block.
`timescale 1ns/1ps
module dps_debug_pins_properties #(
   parameter NUM_TIMERS = 4
) (
   input wire                  clk_in,
   input wire                  rst_n_in,
   input wire                  wb_cyc_in,
   input wire                  wb_stb_in,
   input wire                  wb_we_in,
   input wire                  wb_ack_out,
   input wire [3:0]            pin_ie_out,
   input wire [3:0]            pin_pullup_out,
   input wire [3:0]            pin_pulldown_out,
   input wire                  dbg_clk_level_out,
   input wire                  dbg_clk_rise_out,
   input wire                  dbg_clk_fall_out,
   input wire                  dbg_break_in,
   input wire                  dbg_resume_in,
   input wire                  stop_req_in,
   input wire                  low_power_full_out,
   input wire                  core_halt_out,
   input wire                  watchdog_count_en_out,
   input wire [NUM_TIMERS-1:0] timer_count_en_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   ack_after_req_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack missing one cycle after request");
   ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   reset_pads_a: assert property ($rose(rst_n_in) |=> pin_ie_out == 4'hb && pin_pullup_out == 4'h9 &&
      pin_pulldown_out == 4'h2) else $error("pad controls wrong after reset");
   break_halt_a: assert property (dbg_break_in |-> ##2 core_halt_out)
      else $error("break did not halt the core");
   resume_run_a: assert property (dbg_resume_in && !dbg_break_in |-> ##2 !core_halt_out)
      else $error("resume did not clear halt");
   watchdog_halt_a: assert property (core_halt_out && $past(core_halt_out) |-> !watchdog_count_en_out)
      else $error("watchdog counting in halt");
   timers_run_a: assert property ($past(rst_n_in) && !core_halt_out && !$past(core_halt_out) |->
      watchdog_count_en_out && timer_count_en_out == {NUM_TIMERS{1'b1}}) else $error("counters stopped while running");
   low_power_a: assert property ($past(rst_n_in) && !$past(stop_req_in) |-> !low_power_full_out)
      else $error("low power without stop");
   clk_rise_a: assert property (dbg_clk_rise_out |-> dbg_clk_level_out && !$past(dbg_clk_level_out)
      ##1 !dbg_clk_rise_out) else $error("probe clock rise pulse wrong");
   clk_fall_a: assert property (dbg_clk_fall_out |-> !dbg_clk_level_out && $past(dbg_clk_level_out))
      else $error("probe clock fall pulse wrong");
   halt_seen_c: cover property (dbg_break_in ##2 core_halt_out);
   clk_seen_c: cover property (dbg_clk_rise_out);
   write_seen_c: cover property (wb_we_in && wb_ack_out);
   stop_seen_c: cover property (stop_req_in && low_power_full_out);
endmodule
bind dps_debug_pins dps_debug_pins_properties #(.NUM_TIMERS(NUM_TIMERS)) props_i (.clk_in, .rst_n_in,
   .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_ack_out, .pin_ie_out, .pin_pullup_out, .pin_pulldown_out,
   .dbg_clk_level_out, .dbg_clk_rise_out, .dbg_clk_fall_out, .dbg_break_in, .dbg_resume_in, .stop_req_in,
   .low_power_full_out, .core_halt_out, .watchdog_count_en_out, .timer_count_en_out);

//--- bench/testbench.sv
// Self-checking testbench for the debug pin sharing block with a probe model.
`timescale 1ns/1ps
`include "dps_map.vh"
module testbench;
   reg         clk_in   = 1'b0;
   reg         rst_n_in = 1'b0;
   reg         cyc      = 1'b0;
   reg         stb      = 1'b0;
   reg         we       = 1'b0;
   reg  [7:0]  adr      = 8'h00;
   reg  [31:0] wdat     = 32'h0;
   reg         sd       = 1'b0;
   reg         so       = 1'b0;
   reg         tdo      = 1'b1;
   reg         trc      = 1'b0;
   reg         brk      = 1'b0;
   reg         res      = 1'b0;
   reg         stop     = 1'b0;
   reg  [31:0] q;
   integer     errors    = 0;
   integer     cmp_count = 0;
   integer     rises     = 0;
   integer     falls     = 0;
   wire [31:0] rdat;
   wire        ack, tms, tdi, lvl, swd, lpf, halt, wdt_en, rise, fall;
   wire [3:0]  pin_in, pin_out, pin_oe_out, pin_ie, pu, pd, p_drv, p_oe, tmr_en;
   // Pad wire: device drive wins, then the probe, then the pull; a floating line without pull flips.
   assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & p_oe & p_drv) |
                   (~pin_oe_out & ~p_oe & (pu | (~pd & ~pin_out)));
   dps_debug_pins dps_debug_pins_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pin_ie_out(pin_ie), .pin_pullup_out(pu),
      .pin_pulldown_out(pd), .dbg_tms_swdio_out(tms), .dbg_tdi_out(tdi), .dbg_clk_level_out(lvl),
      .dbg_clk_rise_out(rise), .dbg_clk_fall_out(fall), .dbg_swd_mode_out(swd), .dbg_swdio_data_in(sd),
      .dbg_swdio_oe_in(so), .dbg_tdo_in(tdo), .dbg_trace_in(trc), .dbg_break_in(brk), .dbg_resume_in(res),
      .stop_req_in(stop), .low_power_full_out(lpf), .core_halt_out(halt), .watchdog_count_en_out(wdt_en),
      .timer_count_en_out(tmr_en));
   dps_probe probe_i (.drv_out(p_drv), .oe_out(p_oe));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (rise === 1'b1) rises <= rises + 1;
      if (fall === 1'b1) falls <= falls + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      begin
         if (errors == 0 && cmp_count > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input [8*10:1] name, input [31:0] exp, input [31:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   // Classic single cycle; only the watchdog ends a wait for an ack that never comes.
   task wb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk_in);
         {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
         n = 0;
         @(posedge clk_in);
         while (ack !== 1'b1) begin
            n = n + 1;
            @(posedge clk_in);
         end
         q = rdat;
         {cyc, stb} <= 2'b00;
         chk("ack_lat", 1, n);
      end
   endtask
   task rd_chk(input [8*10:1] name, input [7:0] a, input [31:0] exp);
      begin
         wb(1'b0, a, 32'h0);
         chk(name, exp, q);
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk_in);
         #1;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      tick(2);
      chk("oe_rst", 4'h4, pin_oe_out);
      chk("tdo", 1, pin_out[2]);
      rd_chk("func", `DPS_ADR_FUNC, 32'hf);
      rd_chk("ie", `DPS_ADR_IE, 32'hb);
      rd_chk("oe", `DPS_ADR_OE, 32'h5);
      rd_chk("od", `DPS_ADR_OD, 32'h0);
      rd_chk("pup", `DPS_ADR_PUP, 32'h9);
      rd_chk("pdn", `DPS_ADR_PDN, 32'h2);
      rd_chk("status", `DPS_ADR_STATUS, 32'hf0);
      rd_chk("unmapped", 8'h3c, 32'h0);
      probe_i.frame(8'ha4, 8'h3d, 1'b0);
      tick(6);
      chk("rises", 8, rises);
      chk("falls", 8, falls);
      chk("tms", 3'b001, {lvl, tms, tdi});
      wb(1'b1, `DPS_ADR_DBG_CFG, 32'h1);
      wb(1'b1, `DPS_ADR_OE, 32'hd);
      wb(1'b1, `DPS_ADR_GP_OUT, 32'h8);
      @(posedge clk_in) {sd, so} <= 2'b11;
      tick(6);
      chk("tdi_swd", 2'b01, {tdi, swd});
      chk("pin6_gp", 2'b11, {pin_oe_out[3], pin_out[3]});
      chk("swdio", 2'b11, {pin_oe_out[0], pin_out[0]});
      chk("pin5_gp", 2'b10, {pin_oe_out[2], pin_out[2]});
      rd_chk("own_swd", `DPS_ADR_STATUS, 32'h30);
      @(posedge clk_in) so <= 1'b0;
      tick(2);
      rises = 0;
      falls = 0;
      probe_i.frame(8'h5a, 8'h00, 1'b1);
      tick(6);
      chk("swd_in", 9'h010, {rises[7:0], tms});
      chk("swd_falls", 8, falls);
      wb(1'b1, `DPS_ADR_DBG_CFG, 32'h3);
      @(posedge clk_in) {trc, so, stop} <= 3'b111;
      tick(6);
      chk("stop_oe", 4'b0101, pin_oe_out);
      chk("trace", 2'b10, {pin_out[2], lpf});
      rd_chk("own_trc", `DPS_ADR_STATUS, 32'h72);
      wb(1'b1, `DPS_ADR_STANDBY, 32'h1);
      wb(1'b1, `DPS_ADR_FUNC, 32'hd);
      tick(3);
      chk("stby_lp", 2'b11, {pin_oe_out[3], lpf});
      wb(1'b1, `DPS_ADR_FUNC, 32'h0);
      tick(3);
      rd_chk("own_off", `DPS_ADR_STATUS, 32'h06);
      rd_chk("gp_in", `DPS_ADR_GP_IN, 32'h8);
      wb(1'b1, `DPS_ADR_FUNC, 32'hf);
      wb(1'b1, `DPS_ADR_DBG_CFG, 32'h500);
      @(posedge clk_in) {brk, stop} <= 2'b10;
      @(posedge clk_in) brk <= 1'b0;
      tick(3);
      chk("halt", 6'h2a, {halt, wdt_en, tmr_en});
      @(posedge clk_in) res <= 1'b1;
      @(posedge clk_in) res <= 1'b0;
      tick(3);
      chk("run", 6'h1f, {halt, wdt_en, tmr_en});
      conclude;
   end
   initial begin
      #100000;
      errors = errors + 1;
      conclude;
   end
endmodule
